/* hdl/iaau_cfg.svh */
// Fixed locations, field positions, reset values and counts of the
// indirect address and auto-index unit.
// Assumes a 14-bit byte address of six page bits and eight byte bits.
`ifndef IAAU_CFG_SVH
`define IAAU_CFG_SVH

// Restart points, fixed in hardware
`define IAAU_RESTART_STD    14'h0000
`define IAAU_RESTART_ACP    14'h017C

// Interrupt service table
`define IAAU_INT_BASE       14'h0100
`define IAAU_INT_MAX_LINES  8
`define IAAU_INT_STD_LINES  4

// Read-only low core when the auto load panel is fitted
`define IAAU_LOW_ROM_BYTES  64

// Address word fields
`define IAAU_AIDX_BIT       15
`define IAAU_ASKP_BIT       14
`define IAAU_ADDR_W         14
`define IAAU_PAGE_BYTES     256

// Skip and link distances and end-of-page byte
`define IAAU_SKIP_BYTES     14'h0002
`define IAAU_LINK_BYTES     14'h0002
`define IAAU_BYTE_LAST      8'hFF

// Reset values
`define IAAU_LC_RESET       14'h0000

`endif

/* hdl/iaau_pkg.sv */
// Types shared by the indirect address and auto-index unit.
// Assumes the field layout of iaau_cfg.svh.
package iaau_pkg;

   // Operations requested by the instruction sequencer
   typedef enum logic [2:0] {
      IAAU_OP_DIRECT  = 3'h0,
      IAAU_OP_IND     = 3'h1,
      IAAU_OP_BR_IND  = 3'h2,
      IAAU_OP_BRANCH_AND_LINK     = 3'h3,
      IAAU_OP_INCREMENT_SKIP_ZERO = 3'h4,
      IAAU_OP_TEST_AND_SKIP       = 3'h5,
      IAAU_OP_INTR    = 3'h6,
      IAAU_OP_RESTART = 3'h7
   } iaau_op_type;

   // Gray along read-high, read-low, write-low, finish
   typedef enum logic [2:0] {
      IAAU_ST_IDLE   = 3'h0,
      IAAU_ST_RD_HI  = 3'h1,
      IAAU_ST_RD_LO  = 3'h3,
      IAAU_ST_WR_LO  = 3'h7,
      IAAU_ST_FINISH = 3'h6,
      IAAU_ST_WR_HI  = 3'h4
   } iaau_state_type;

   // Sixteen-bit address word, flags on top
   typedef struct packed {
      logic       autoindex_flag;
      logic       autoskip_flag;
      logic [5:0] page;
      logic [7:0] byte_loc;
   } iaau_aword_type;

   // One request from the sequencer
   typedef struct packed {
      iaau_op_type op;
      logic [7:0]  disp;
      logic        zero_page;
      logic [13:0] instr_last;
      logic [13:0] lc;
      logic        carry;
      logic [2:0]  line;
   } iaau_cmd_type;

   // Answer to the sequencer
   typedef struct packed {
      logic [13:0] ea;
      logic [13:0] next_lc;
      logic        skip;
      logic        err;
   } iaau_res_type;

endpackage

/* hdl/iaau_autoinc.sv */
// Auto-index and auto-skip evaluation of one address word.
// Assumes the word arrives whole; purely combinational.
`timescale 1ns/1ps
`include "iaau_cfg.svh"

module iaau_autoinc (
   input  wire iaau_pkg::iaau_aword_type aword,
   output logic [13:0]                   ea,
   output logic [7:0]                    byte_next,
   output logic                          skip
);

   // Byte field bumps alone; its carry is dropped, page stays
   assign byte_next = aword.autoindex_flag ?
                      8'(aword.byte_loc + 8'h01) : aword.byte_loc;
   // Flags never reach the address
   assign ea        = {aword.page, byte_next};
   // Skip when auto-skip is flagged, unless the bumped byte sits at the end of the page
   assign skip      = aword.autoskip_flag &&
                      (byte_next != `IAAU_BYTE_LAST);

endmodule

/* hdl/iaau_fixmap.sv */
// Fixed hardware locations: restart point, service table, low core.
// Assumes the option straps are steady while the unit runs.
`timescale 1ns/1ps
`include "iaau_cfg.svh"

module iaau_fixmap #(
   parameter int INT_LINES = `IAAU_INT_MAX_LINES,
   parameter int ROM_BYTES = `IAAU_LOW_ROM_BYTES
) (
   input  wire logic [2:0]  line,
   input  wire logic        ext_fitted,
   input  wire logic        acp_fitted,
   input  wire logic        alp_fitted,
   input  wire logic [13:0] wr_addr,
   output logic [13:0]      vec_addr,
   output logic             line_ok,
   output logic [13:0]      restart_addr,
   output logic             write_ok
);

   logic [7:0] present;

   if (INT_LINES > 8 || INT_LINES < `IAAU_INT_STD_LINES) begin : g_bad
      $error("iaau_fixmap: INT_LINES out of range");
   end
   if (ROM_BYTES > `IAAU_PAGE_BYTES) begin : g_bad_rom
      $error("iaau_fixmap: ROM_BYTES above one page");
   end

   // Low lines always exist, the rest only with the extension
   for (genvar i = 0; i < 8; i++) begin : g_line
      assign present[i] = (i < `IAAU_INT_STD_LINES) ||
                          ((i < INT_LINES) && ext_fitted);
   end

   // Eight-byte block per line
   assign vec_addr     = 14'(`IAAU_INT_BASE + {8'h00, line, 3'h0});
   assign line_ok      = present[line];
   assign restart_addr = acp_fitted ? `IAAU_RESTART_ACP
                                    : `IAAU_RESTART_STD;
   // Frozen low core swallows writes
   assign write_ok     = !(alp_fitted && (wr_addr < 14'(ROM_BYTES)));

endmodule

/* hdl/iaau_top.sv */
// Effective address, auto-index and skip sequencing for a byte-wide
// page-addressed processor.
// Assumes core memory answers each held request with a one-cycle ack,
// read data valid with that ack, and straps steady after reset.
`timescale 1ns/1ps
`include "iaau_cfg.svh"

module iaau_top #(
   parameter int INT_LINES = `IAAU_INT_MAX_LINES,
   parameter int ROM_BYTES = `IAAU_LOW_ROM_BYTES
) (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic                 cmd_valid,
   input  wire iaau_pkg::iaau_cmd_type cmd,
   output iaau_pkg::iaau_res_type    result,
   output logic                      done,
   output logic                      cmd_ready,
   input  wire logic                 acp_fitted,
   input  wire logic                 alp_fitted,
   input  wire logic                 ext_fitted,
   output logic                      mem_req,
   output logic                      mem_we,
   output logic [13:0]               mem_addr,
   output logic [7:0]                mem_wdata,
   input  wire logic                 mem_ack,
   input  wire logic [7:0]           mem_rdata
);

   if (`IAAU_ADDR_W != 14) begin : g_bad_w
      $error("iaau_top: address width must be 14");
   end

   ////////////////////////////////////////////////////////////////////
   // Declarations

   iaau_pkg::iaau_state_type state_q, state_d;
   iaau_pkg::iaau_op_type    op_q;
   iaau_pkg::iaau_res_type   res_d;
   iaau_pkg::iaau_aword_type aword_w;
   logic [13:0] ptr_q, link_q, lc_q;
   logic [7:0]  hi_q;
   logic        boot_q;
   logic        take, bus_done, is_wr_d, is_bus_d, rd_lo_end;
   logic [13:0] direct_ea, tgt_w, ptr_w, link_w, addr_d, vec_addr;
   logic [13:0] restart_addr, lo_addr_w, ai_ea;
   logic [7:0]  ai_byte, inc_val, wdata_d;
   logic        ai_skip, line_ok, write_ok, inc_zero;
   iaau_pkg::iaau_op_type op_w;

   ////////////////////////////////////////////////////////////////////
   // Decode of the request and of address sources

   assign take      = cmd_valid && cmd_ready;
   assign op_w      = take ? cmd.op : op_q;
   // Current page is the page of the instruction's last byte
   assign direct_ea = {cmd.zero_page ? 6'h00 : cmd.instr_last[13:8],
                       cmd.disp};
   assign tgt_w     = (cmd.op == iaau_pkg::IAAU_OP_INTR) ? vec_addr
                                                        : direct_ea;
   assign ptr_w     = take ? tgt_w : ptr_q;
   assign link_w    = take ? cmd.lc : link_q;
   // Counted byte sits at the pointer, word low half at +1
   assign lo_addr_w = (op_w == iaau_pkg::IAAU_OP_INCREMENT_SKIP_ZERO) ?
                      ptr_w : 14'(ptr_w + 14'h0001);
   // Bus cycle over when acked, or when a write was swallowed
   assign bus_done  = mem_ack || !mem_req;
   assign rd_lo_end = (state_q == iaau_pkg::IAAU_ST_RD_LO) && mem_ack;
   // Word assembled from the latched high byte and the arriving low
   assign aword_w   = {hi_q, mem_rdata};
   assign inc_val   = 8'(mem_rdata + 8'h01);
   assign inc_zero  = (inc_val == 8'h00);

   iaau_autoinc u_autoinc (
      .aword     (aword_w),
      .ea        (ai_ea),
      .byte_next (ai_byte),
      .skip      (ai_skip)
   );

   iaau_fixmap #(
      .INT_LINES (INT_LINES),
      .ROM_BYTES (ROM_BYTES)
   ) u_fixmap (
      .line         (cmd.line),
      .ext_fitted   (ext_fitted),
      .acp_fitted   (acp_fitted),
      .alp_fitted   (alp_fitted),
      .wr_addr      (addr_d),
      .vec_addr     (vec_addr),
      .line_ok      (line_ok),
      .restart_addr (restart_addr),
      .write_ok     (write_ok)
   );

   ////////////////////////////////////////////////////////////////////
   // Sequencer

   // Next state per operation
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         iaau_pkg::IAAU_ST_IDLE: begin
            if (take) begin
               unique case (cmd.op)
                  iaau_pkg::IAAU_OP_IND,
                  iaau_pkg::IAAU_OP_BR_IND:  state_d = iaau_pkg::IAAU_ST_RD_HI;
                  iaau_pkg::IAAU_OP_INCREMENT_SKIP_ZERO:
                     state_d = iaau_pkg::IAAU_ST_RD_LO;
                  iaau_pkg::IAAU_OP_BRANCH_AND_LINK:
                     state_d = iaau_pkg::IAAU_ST_WR_HI;
                  iaau_pkg::IAAU_OP_INTR:    state_d = line_ok ?
                     iaau_pkg::IAAU_ST_WR_HI : iaau_pkg::IAAU_ST_FINISH;
                  default:                   state_d = iaau_pkg::IAAU_ST_FINISH;
               endcase
            end
         end
         iaau_pkg::IAAU_ST_RD_HI:
            if (mem_ack) state_d = iaau_pkg::IAAU_ST_RD_LO;
         // Write back only the low byte: flags and page untouched
         iaau_pkg::IAAU_ST_RD_LO:
            if (mem_ack) state_d =
               (op_q == iaau_pkg::IAAU_OP_INCREMENT_SKIP_ZERO ||
                aword_w.autoindex_flag) ?
               iaau_pkg::IAAU_ST_WR_LO : iaau_pkg::IAAU_ST_FINISH;
         iaau_pkg::IAAU_ST_WR_HI:
            if (bus_done) state_d = iaau_pkg::IAAU_ST_WR_LO;
         iaau_pkg::IAAU_ST_WR_LO:
            if (bus_done) state_d = iaau_pkg::IAAU_ST_FINISH;
         iaau_pkg::IAAU_ST_FINISH: state_d = iaau_pkg::IAAU_ST_IDLE;
         default:                  state_d = iaau_pkg::IAAU_ST_IDLE;
      endcase
   end

   // Bus address and data for the state being entered
   assign is_wr_d  = (state_d == iaau_pkg::IAAU_ST_WR_HI) ||
                     (state_d == iaau_pkg::IAAU_ST_WR_LO);
   assign is_bus_d = is_wr_d || (state_d == iaau_pkg::IAAU_ST_RD_HI) ||
                     (state_d == iaau_pkg::IAAU_ST_RD_LO);
   assign addr_d   = (state_d == iaau_pkg::IAAU_ST_RD_HI ||
                      state_d == iaau_pkg::IAAU_ST_WR_HI) ? ptr_w
                                                          : lo_addr_w;
   // Return address stored high byte first, flags clear
   assign wdata_d  = (state_d == iaau_pkg::IAAU_ST_WR_HI) ?
                        {2'h0, link_w[13:8]} :
                     !rd_lo_end ? link_w[7:0] :
                     (op_q == iaau_pkg::IAAU_OP_INCREMENT_SKIP_ZERO) ?
                        inc_val : ai_byte;

   ////////////////////////////////////////////////////////////////////
   // Answer to the sequencer

   always_comb begin
      res_d = result;
      if (take) begin
         res_d = '{ea: tgt_w, next_lc: cmd.lc, skip: 1'b0, err: 1'b0};
         unique case (cmd.op)
            iaau_pkg::IAAU_OP_TEST_AND_SKIP: begin
               res_d.skip    = !cmd.carry;
               res_d.next_lc = cmd.carry ? cmd.lc :
                               14'(cmd.lc + `IAAU_SKIP_BYTES);
            end
            iaau_pkg::IAAU_OP_BRANCH_AND_LINK:
               res_d.next_lc = 14'(tgt_w + `IAAU_LINK_BYTES);
            iaau_pkg::IAAU_OP_INTR: begin
               res_d.err     = !line_ok;
               res_d.next_lc = line_ok ?
                               14'(tgt_w + `IAAU_LINK_BYTES) : cmd.lc;
            end
            iaau_pkg::IAAU_OP_RESTART: begin
               res_d.ea      = restart_addr;
               res_d.next_lc = restart_addr;
            end
            default: ;
         endcase
      end else if (rd_lo_end) begin
         unique case (op_q)
            iaau_pkg::IAAU_OP_INCREMENT_SKIP_ZERO: begin
               res_d.skip    = inc_zero;
               res_d.next_lc = inc_zero ?
                               14'(lc_q + `IAAU_SKIP_BYTES) : lc_q;
            end
            iaau_pkg::IAAU_OP_BR_IND: begin
               res_d.ea      = ai_ea;
               res_d.next_lc = ai_ea;
            end
            default: begin
               // Incremented address used at once
               res_d.ea      = ai_ea;
               res_d.skip    = ai_skip;
               res_d.next_lc = ai_skip ?
                               14'(lc_q + `IAAU_SKIP_BYTES) : lc_q;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Registers

   // Sequencer state and operands
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_q <= iaau_pkg::IAAU_ST_IDLE;
         op_q    <= iaau_pkg::IAAU_OP_DIRECT;
         ptr_q   <= `IAAU_LC_RESET;
         link_q  <= `IAAU_LC_RESET;
         lc_q    <= `IAAU_LC_RESET;
         hi_q    <= 8'h00;
      end else begin
         state_q <= state_d;
         op_q    <= op_w;
         ptr_q   <= ptr_w;
         link_q  <= link_w;
         if (take) lc_q <= cmd.lc;
         if (state_q == iaau_pkg::IAAU_ST_RD_HI && mem_ack)
            hi_q <= mem_rdata;
      end
   end

   // Bus outputs; a swallowed low-core write raises no request
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         mem_req   <= 1'b0;
         mem_we    <= 1'b0;
         mem_addr  <= `IAAU_LC_RESET;
         mem_wdata <= 8'h00;
      end else begin
         mem_req   <= is_bus_d && (!is_wr_d || write_ok);
         // Qualifiers frozen while a request waits on a slow module
         if (!mem_req || mem_ack) begin
            mem_we    <= is_wr_d;
            mem_addr  <= addr_d;
            mem_wdata <= wdata_d;
         end
      end
   end

   // Answer; power-up restart caught one cycle after release
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         result    <= '{ea: `IAAU_LC_RESET, next_lc: `IAAU_LC_RESET,
                        skip: 1'b0, err: 1'b0};
         boot_q    <= 1'b1;
         done      <= 1'b0;
         cmd_ready <= 1'b0;
      end else begin
         boot_q    <= 1'b0;
         done      <= (state_d == iaau_pkg::IAAU_ST_FINISH);
         cmd_ready <= (state_d == iaau_pkg::IAAU_ST_IDLE) && !boot_q;
         if (boot_q)
            result <= '{ea: restart_addr, next_lc: restart_addr,
                        skip: 1'b0, err: 1'b0};
         else
            result <= res_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_guard_low_core: assert property (mem_req && mem_we && alp_fitted
      |-> mem_addr >= 14'(ROM_BYTES)) else $error("low core written");
   a_boot_restart: assert property (boot_q && !acp_fitted
      |=> result.next_lc == `IAAU_RESTART_STD) else $error("bad restart");
   a_boot_acp: assert property (boot_q && acp_fitted
      |=> result.next_lc == `IAAU_RESTART_ACP) else $error("bad acp start");
   a_test_skip: assert property (take &&
      cmd.op == iaau_pkg::IAAU_OP_TEST_AND_SKIP
      |=> done && result.skip == !$past(cmd.carry)) else $error("test skip");
   a_link_next: assert property (take &&
      cmd.op == iaau_pkg::IAAU_OP_BRANCH_AND_LINK
      |=> result.next_lc == 14'(ptr_q + 14'h0002)) else $error("link next");
   a_wb_low_only: assert property (mem_req && mem_we &&
      (op_q == iaau_pkg::IAAU_OP_IND || op_q == iaau_pkg::IAAU_OP_BR_IND)
      |-> mem_addr == 14'(ptr_q + 14'h0001)) else $error("word hi written");
   a_autoidx_ea: assert property (rd_lo_end &&
      op_q == iaau_pkg::IAAU_OP_IND && aword_w.autoindex_flag
      |=> result.ea[7:0] == 8'($past(mem_rdata) + 8'h01) &&
          result.ea[13:8] == $past(hi_q[5:0])) else $error("autoindex ea");
   a_autoskip: assert property (rd_lo_end && op_q == iaau_pkg::IAAU_OP_IND
      |=> result.skip == ($past(hi_q[6]) && result.ea[7:0] != 8'hFF))
      else $error("autoskip test");
   a_intr_vector: assert property (take && cmd.op == iaau_pkg::IAAU_OP_INTR
      && line_ok |=> result.ea == 14'h0100 + 14'({$past(cmd.line), 3'h0}))
      else $error("service block address");
   a_req_hold: assert property (mem_req && !mem_ack
      |=> mem_req && $stable(mem_addr) && $stable(mem_we) &&
          $stable(mem_wdata)) else $error("request dropped");
   a_inc_skip: assert property (rd_lo_end &&
      op_q == iaau_pkg::IAAU_OP_INCREMENT_SKIP_ZERO
      |=> result.skip == ($past(mem_rdata) == 8'hFF) ##[1:2] done)
      else $error("increment skip");

endmodule

/* testbench/iaau_mem.sv */
// Behavioural core memory on the processor memory bus of the unit.
// Assumes the unit holds each request until it sees the one-cycle ack.
`timescale 1ns/1ps

module iaau_mem (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        slow,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [13:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   output logic             mem_ack,
   output logic [7:0]       mem_rdata
);
   ////////////////////////////////////////////////////////////////////
   // Storage, open to the bench for preload and inspection
   logic [7:0] mem [0:16383];
   logic [1:0] wait_q;

   ////////////////////////////////////////////////////////////////////
   // One ack per held request; outside the ack cycle the data lines
   // flip each cycle so stale read data can never look valid
   always @(posedge sys_clk) begin
      if (rst) begin
         mem_ack <= 1'b0;
         wait_q <= 2'h0;
         mem_rdata <= 8'h5A;
      end else if (mem_ack || !mem_req) begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
      end else if (wait_q == (slow ? 2'h3 : 2'h0)) begin
         mem_ack <= 1'b1;
         wait_q <= 2'h0;
         if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
            mem_rdata <= ~mem_rdata;
         end else begin
            mem_rdata <= mem[mem_addr];
         end
      end else begin
         wait_q <= wait_q + 2'h1;
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule

/* testbench/iaau_top_test.sv */
// Self-checking bench of the address and auto-index unit.
// Assumes the memory model iaau_mem stands on the memory bus.
`timescale 1ns/1ps

module iaau_top_test;
   logic                   sys_clk;
   logic                   rst;
   logic                   cmd_valid;
   iaau_pkg::iaau_cmd_type cmd;
   iaau_pkg::iaau_res_type res;
   logic                   done;
   logic                   cmd_ready;
   logic                   acp;
   logic                   alp;
   logic                   ext;
   logic                   slow;
   logic                   req;
   logic                   we;
   logic [13:0]            addr;
   logic [7:0]             wdata;
   logic                   ack;
   logic [7:0]             rdata;
   int                     failures;
   int                     checks;
   int                     cycles;

   iaau_top iaau_top_inst (.sys_clk(sys_clk), .rst(rst),
      .cmd_valid(cmd_valid), .cmd(cmd), .result(res), .done(done),
      .cmd_ready(cmd_ready), .acp_fitted(acp), .alp_fitted(alp),
      .ext_fitted(ext), .mem_req(req), .mem_we(we), .mem_addr(addr),
      .mem_wdata(wdata), .mem_ack(ack), .mem_rdata(rdata));

   iaau_mem iaau_mem_inst (.sys_clk(sys_clk), .rst(rst), .slow(slow),
      .mem_req(req), .mem_we(we), .mem_addr(addr), .mem_wdata(wdata),
      .mem_ack(ack), .mem_rdata(rdata));

   ////////////////////////////////////////////////////////////////////
   // 40 MHz clock and a hang guard well above the expected run
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         failures++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Verdict and comparison
   task automatic summarize();
      if (failures == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One request; page-zero targets pretend the instruction is on page 3
   task automatic run(input iaau_pkg::iaau_op_type op,
                      input logic [13:0] adr, input logic [13:0] lc,
                      input logic cy, input logic [2:0] ln);
      logic zp;
      zp = (adr[13:8] == 6'h00);
      @(negedge sys_clk);
      while (cmd_ready !== 1'b1) @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd = '{op, adr[7:0], zp, zp ? 14'h03FE : {adr[13:8], 8'hFE},
              lc, cy, ln};
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      while (done !== 1'b1) @(negedge sys_clk);
   endtask

   ////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_restart();
      @(negedge sys_clk);
      while (cmd_ready !== 1'b1) @(negedge sys_clk);
      check("power-up ea", res.ea, 16'h0000);
      acp = 1'b1;
      run(iaau_pkg::IAAU_OP_RESTART, 14'h0000, 14'h0000, 1'b0, 3'h0);
      check("acp restart", res.next_lc, 16'h017C);
      acp = 1'b0;
      run(iaau_pkg::IAAU_OP_RESTART, 14'h0000, 14'h0000, 1'b0, 3'h0);
      check("std restart", res.next_lc, 16'h0000);
      // Second power-up, now with the control panel strap fitted
      acp = 1'b1;
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      @(negedge sys_clk);
      while (cmd_ready !== 1'b1) @(negedge sys_clk);
      check("acp power-up ea", res.ea, 16'h017C);
      acp = 1'b0;
   endtask

   task automatic t_direct();
      run(iaau_pkg::IAAU_OP_DIRECT, 14'h0012, 14'h0500, 1'b0, 3'h0);
      check("page zero ea", res.ea, 16'h0012);
      run(iaau_pkg::IAAU_OP_DIRECT, 14'h0455, 14'h0200, 1'b0, 3'h0);
      check("current page ea", res.ea, 16'h0455);
   endtask

   // Expectations derived per word: bump byte if indexed, skip if flagged and not FF
   task automatic t_ind();
      logic [15:0] w [5];
      logic [7:0]  b;
      w = '{16'h87FF, 16'hC8FF, 16'h40FF, 16'hC355, 16'h43FE};
      foreach (w[i]) begin
         // Odd words on slow memory: write-back must hold its data
         slow = i[0];
         iaau_mem_inst.mem[14'h0020] = w[i][15:8];
         iaau_mem_inst.mem[14'h0021] = w[i][7:0];
         b = w[i][7:0] + {7'h00, w[i][15]};
         run(iaau_pkg::IAAU_OP_IND, 14'h0020, 14'h0600, 1'b0, 3'h0);
         check("indirect ea", res.ea, {2'h0, w[i][13:8], b});
         check("skip", res.skip, w[i][14] && b != 8'hFF);
         check("next lc", res.next_lc,
               (w[i][14] && b != 8'hFF) ? 16'h0602 : 16'h0600);
         check("word hi", iaau_mem_inst.mem[14'h0020],
               w[i][15:8]);
         check("word lo", iaau_mem_inst.mem[14'h0021], b);
      end
      slow = 1'b0;
   endtask

   // Slow memory: link, then return through the linked word
   task automatic t_link();
      slow = 1'b1;
      run(iaau_pkg::IAAU_OP_BRANCH_AND_LINK, 14'h0330, 14'h1234, 1'b0,
          3'h0);
      check("link hi", iaau_mem_inst.mem[14'h0330], 16'h0012);
      check("link lo", iaau_mem_inst.mem[14'h0331], 16'h0034);
      check("link next", res.next_lc, 16'h0332);
      run(iaau_pkg::IAAU_OP_BR_IND, 14'h0330, 14'h0000, 1'b0, 3'h0);
      check("return", res.next_lc, 16'h1234);
      slow = 1'b0;
   endtask

   task automatic t_inc_skip();
      iaau_mem_inst.mem[14'h0340] = 8'hFF;
      iaau_mem_inst.mem[14'h0341] = 8'h05;
      for (int i = 0; i < 2; i++) begin
         run(iaau_pkg::IAAU_OP_INCREMENT_SKIP_ZERO, 14'(14'h0340 + i),
             14'h0500, 1'b0, 3'h0);
         check("inc byte", iaau_mem_inst.mem[14'h0340 + i],
               i ? 16'h0006 : 16'h0000);
         check("inc skip", res.skip, i == 0);
         check("inc lc", res.next_lc, i ? 16'h0500 : 16'h0502);
      end
   endtask

   task automatic t_test_skip();
      for (int i = 0; i < 2; i++) begin
         run(iaau_pkg::IAAU_OP_TEST_AND_SKIP, 14'h0000, 14'h0600, i[0],
             3'h0);
         check("test skip", res.skip, !i[0]);
         check("test skip lc", res.next_lc, i ? 16'h0600 : 16'h0602);
      end
   endtask

   // Line 5 is refused without the extension, line 7 served with it
   task automatic t_intr();
      logic [2:0] ln;
      for (int i = 0; i < 3; i++) begin
         ln = (i == 0) ? 3'h2 : (i == 1) ? 3'h5 : 3'h7;
         ext = (i == 2);
         run(iaau_pkg::IAAU_OP_INTR, 14'h0000, 14'h0700, 1'b0, ln);
         check("intr err", res.err, i == 1);
         check("intr lc", res.next_lc, (i == 1) ? 16'h0700
               : 16'h0102 + {ln, 3'h0});
      end
      ext = 1'b0;
   endtask

   // Low core guarded below 64 only
   task automatic t_alp();
      alp = 1'b1;
      iaau_mem_inst.mem[14'h003E] = 8'h11;
      iaau_mem_inst.mem[14'h003F] = 8'h22;
      run(iaau_pkg::IAAU_OP_BRANCH_AND_LINK, 14'h003E, 14'h0777, 1'b0,
          3'h0);
      check("rom hi", iaau_mem_inst.mem[14'h003E], 16'h0011);
      check("rom lo", iaau_mem_inst.mem[14'h003F], 16'h0022);
      run(iaau_pkg::IAAU_OP_BRANCH_AND_LINK, 14'h0040, 14'h0777, 1'b0,
          3'h0);
      check("ram lo", iaau_mem_inst.mem[14'h0041], 16'h0077);
      alp = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      sys_clk = 1'b0;
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd = '0;
      {acp, alp, ext, slow} = 4'h0;
      failures = 0;
      checks = 0;
      cycles = 0;
      repeat (20) @(negedge sys_clk);
      rst = 1'b0;
      t_restart();
      t_direct();
      t_ind();
      t_link();
      t_inc_skip();
      t_test_skip();
      t_intr();
      t_alp();
      summarize();
   end
endmodule
